/* src/link_drop_regs_pkg.sv */
// Register map, field layout and timing constants of the link drop
// and extended access register bank. Needs nothing else.
package link_drop_regs_pkg;

   // Register indices; byte address is four times the index
   localparam int unsigned REG_IDX_W = 6;
   localparam logic [REG_IDX_W-1:0] IDX_LINK_CONTROL_THREE      = 6'h0b;
   localparam logic [REG_IDX_W-1:0] IDX_EXTENDED_ACCESS_CONTROL = 6'h0d;
   localparam logic [REG_IDX_W-1:0] IDX_EXTENDED_ADDRESS_DATA   = 6'h0e;
   localparam logic [REG_IDX_W-1:0] IDX_LINK_DROP_CAUSE_STATUS  = 6'h0f;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_STATUS              = 6'h18;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_MASK                = 6'h19;

   // Link control three layout
   localparam logic [15:0] LCT_RESET    = 16'h1000;
   localparam logic [15:0] LCT_RW_MASK  = 16'hf7ff;
   localparam int unsigned LCT_EQ_ERR   = 12;
   localparam int unsigned LCT_DESCR    = 10;
   localparam int unsigned LCT_COEF0    = 9;
   localparam int unsigned LCT_POL      = 6;
   localparam int unsigned LCT_XOVER    = 5;
   localparam int unsigned LCT_RXERR    = 3;
   localparam int unsigned LCT_MLT3     = 2;
   localparam int unsigned LCT_SNR      = 1;
   localparam int unsigned LCT_ENERGY   = 0;

   // Extended access control layout
   localparam int unsigned EAC_CMD_HI   = 15;
   localparam int unsigned EAC_CMD_LO   = 14;
   localparam int unsigned EAC_DEV_HI   = 4;
   localparam logic [1:0] CMD_ADDRESS     = 2'h0;
   localparam logic [1:0] CMD_DATA        = 2'h1;
   localparam logic [1:0] CMD_DATA_INC_RW = 2'h2;
   localparam logic [1:0] CMD_DATA_INC_W  = 2'h3;
   localparam logic [4:0] DEV_VENDOR    = 5'h1f;
   localparam logic [4:0] DEV_MMD3      = 5'h03;
   localparam logic [4:0] DEV_MMD7      = 5'h07;
   localparam int unsigned NUM_SPACES   = 3;

   // Cause vector layout, shared by cause status and irq registers
   localparam int unsigned CAUSE_W      = 5;
   localparam int unsigned CAUSE_DESCR  = 4;
   localparam int unsigned CAUSE_RXERR  = 3;
   localparam int unsigned CAUSE_MLT3   = 2;
   localparam int unsigned CAUSE_SNR    = 1;
   localparam int unsigned CAUSE_ENERGY = 0;
   localparam int unsigned LDS_LSB      = 4;

   // Fast link down thresholds and window
   localparam int unsigned RXERR_LIMIT   = 32;
   localparam int unsigned MLT3_LIMIT    = 20;
   localparam int unsigned SNR_LIMIT     = 20;
   localparam int unsigned CNT_W         = 6;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned FLD_WINDOW_US = 10;
   localparam int unsigned WINDOW_CYCLES = (FLD_WINDOW_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned WIN_W         = $clog2(WINDOW_CYCLES);

endpackage : link_drop_regs_pkg

/* src/link_drop_regs.sv */
// Link control three, extended register access and fast link down logic,
// reached over an Avalon-MM slave with waitrequest.
// Assumes event inputs come from PHY logic on clk_i; one master only.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps

module link_drop_regs
   import link_drop_regs_pkg::*;
#(
   parameter int unsigned EXT_AW = 4
) (
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   sys_rst_i,
   // Avalon-MM slave
   input  wire logic [REG_IDX_W+1:0]   address_i,
   input  wire logic                   read_i,
   input  wire logic                   write_i,
   input  wire logic [31:0]            writedata_i,
   input  wire logic [3:0]             byteenable_i,
   output logic      [31:0]            readdata_o,
   output logic                        waitrequest_o,
   // PHY datapath events
   input  wire logic                   rx_err_i,
   input  wire logic                   mlt3_viol_i,
   input  wire logic                   low_snr_i,
   input  wire logic                   energy_lost_i,
   input  wire logic                   descr_loss_i,
   // PHY datapath controls
   output logic                        eq_coef0_bypass_o,
   output logic                        eq_err_bypass_o,
   output logic                        polarity_swap_o,
   output logic                        crossover_swap_o,
   output logic                        port_mirror_o,
   output logic                        link_drop_o,
   // Interrupt
   output logic                        irq_o
);

   localparam int unsigned DEPTH   = 2 ** EXT_AW;
   localparam int unsigned SP_W    = 2;
   // Windowed counters: receive errors, coding violations, low SNR
   localparam int unsigned NUM_CNT = 3;

   logic [15:0]          lct_reg;
   logic [1:0]           cmd_reg;
   logic [4:0]           dev_reg;
   logic [15:0]          ext_addr_reg [NUM_SPACES];
   logic [15:0]          ext_mem      [NUM_SPACES * DEPTH];
   logic [CAUSE_W-1:0]   lds_reg;
   logic [CAUSE_W-1:0]   irq_stat_reg;
   logic [CAUSE_W-1:0]   irq_mask_reg;
   logic [31:0]          readdata_reg;
   logic                 wait_reg;
   logic [WIN_W-1:0]     win_cnt_reg;
   logic [CNT_W-1:0]     err_cnt_reg [NUM_CNT];
   logic                 energy_d_reg;
   logic                 descr_d_reg;
   logic                 mirror_reg;
   logic                 link_drop_reg;
   logic                 irq_reg;

   logic [REG_IDX_W-1:0] idx;
   logic                 ack;
   logic                 wr_ack;
   logic                 rd_ack;
   logic [SP_W:0]        sp_sel;
   logic [SP_W-1:0]      sp;
   logic                 sp_ok;
   logic [15:0]          cur_addr;
   logic [15:0]          cur_data;
   logic                 data_acc;
   logic                 post_inc;
   logic [NUM_CNT-1:0]   cnt_ev;
   logic [NUM_CNT-1:0]   cnt_en;
   logic [NUM_CNT-1:0]   cnt_hit;
   logic [CAUSE_W-1:0]   trig;
   logic                 win_end;

   // Byte lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  be);
      merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
   endfunction : merge16

   // Selector to space index; invalid selectors flagged
   function automatic logic [SP_W:0] space_of(input logic [4:0] dev);
      case (dev)
         DEV_VENDOR: space_of = {1'b1, 2'h0};
         DEV_MMD3:   space_of = {1'b1, 2'h1};
         DEV_MMD7:   space_of = {1'b1, 2'h2};
         default:    space_of = {1'b0, 2'h0};
      endcase
   endfunction : space_of

   // Threshold of each windowed counter
   function automatic logic [CNT_W-1:0] limit_of(input int unsigned i);
      case (i)
         0:       limit_of = CNT_W'(RXERR_LIMIT);
         1:       limit_of = CNT_W'(MLT3_LIMIT);
         default: limit_of = CNT_W'(SNR_LIMIT);
      endcase
   endfunction : limit_of

   assign idx      = address_i[REG_IDX_W+1:2];
   assign ack      = (read_i | write_i) & ~wait_reg;
   assign wr_ack   = ack & write_i;
   assign rd_ack   = ack & read_i;
   assign sp_sel   = space_of(dev_reg);
   assign sp       = sp_sel[SP_W-1:0];
   assign sp_ok    = sp_sel[SP_W];
   assign cur_addr = ext_addr_reg[sp];
   assign cur_data = ext_mem[32'(sp) * DEPTH + 32'(cur_addr[EXT_AW-1:0])];
   assign data_acc = sp_ok & (cmd_reg != CMD_ADDRESS) & (idx == IDX_EXTENDED_ADDRESS_DATA);
   // Increment after qualifying access, write or read by command
   assign post_inc = data_acc & ((cmd_reg == CMD_DATA_INC_RW & (wr_ack | rd_ack))
                               | (cmd_reg == CMD_DATA_INC_W & wr_ack));

   // Avalon handshake: one wait cycle, then a single acknowledge cycle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wait_reg <= 1'b1;
      end else if (ack) begin
         wait_reg <= 1'b1;
      end else if (read_i | write_i) begin
         wait_reg <= 1'b0;
      end
   end

   // Read data captured in the wait cycle, so that a read clear
   // drops exactly the cause bits that the master is handed
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         readdata_reg <= 32'h0;
      end else if (read_i & wait_reg) begin
         case (idx)
            IDX_LINK_CONTROL_THREE:      readdata_reg <= {16'h0, lct_reg};
            IDX_EXTENDED_ACCESS_CONTROL: readdata_reg <= {16'h0, cmd_reg, 9'h0, dev_reg};
            IDX_EXTENDED_ADDRESS_DATA: begin
               if (!sp_ok) begin
                  readdata_reg <= 32'h0;
               end else if (cmd_reg == CMD_ADDRESS) begin
                  readdata_reg <= {16'h0, cur_addr};
               end else begin
                  readdata_reg <= {16'h0, cur_data};
               end
            end
            IDX_LINK_DROP_CAUSE_STATUS:
               readdata_reg <= {16'h0, 7'h0, lds_reg, 4'h0};
            IDX_IRQ_STATUS:              readdata_reg <= {27'h0, irq_stat_reg};
            IDX_IRQ_MASK:                readdata_reg <= {27'h0, irq_mask_reg};
            default:                     readdata_reg <= 32'h0;
         endcase
      end
   end

   // Link control three
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lct_reg <= LCT_RESET;
      end else if (wr_ack && idx == IDX_LINK_CONTROL_THREE) begin
         lct_reg <= merge16(lct_reg, writedata_i[15:0], byteenable_i[1:0]) & LCT_RW_MASK;
      end
   end

   // Extended access control
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cmd_reg <= CMD_ADDRESS;
         dev_reg <= 5'h0;
      end else if (wr_ack && idx == IDX_EXTENDED_ACCESS_CONTROL) begin
         if (byteenable_i[1]) begin
            cmd_reg <= writedata_i[EAC_CMD_HI:EAC_CMD_LO];
         end
         if (byteenable_i[0]) begin
            dev_reg <= writedata_i[EAC_DEV_HI:0];
         end
      end
   end

   // Per-space address registers
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < NUM_SPACES; i++) begin
            ext_addr_reg[i] <= 16'h0;
         end
      end else if (wr_ack && sp_ok && cmd_reg == CMD_ADDRESS &&
                   idx == IDX_EXTENDED_ADDRESS_DATA) begin
         ext_addr_reg[sp] <= merge16(cur_addr, writedata_i[15:0], byteenable_i[1:0]);
      end else if (post_inc) begin
         ext_addr_reg[sp] <= cur_addr + 16'h1;
      end
   end

   // Extended register storage; command 01 writes without increment
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < NUM_SPACES * DEPTH; i++) begin
            ext_mem[i] <= 16'h0;
         end
      end else if (wr_ack && data_acc) begin
         ext_mem[32'(sp) * DEPTH + 32'(cur_addr[EXT_AW-1:0])] <=
            merge16(cur_data, writedata_i[15:0], byteenable_i[1:0]);
      end
   end

   // Ten microsecond interval timer
   assign win_end = (win_cnt_reg == WIN_W'(WINDOW_CYCLES - 1));

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         win_cnt_reg <= '0;
      end else if (win_end) begin
         win_cnt_reg <= '0;
      end else begin
         win_cnt_reg <= win_cnt_reg + WIN_W'(1);
      end
   end

   assign cnt_ev = {low_snr_i, mlt3_viol_i, rx_err_i};
   assign cnt_en = {lct_reg[LCT_SNR], lct_reg[LCT_MLT3], lct_reg[LCT_RXERR]};

   // Enabled event that reaches its threshold within the interval
   always_comb begin
      for (int i = 0; i < NUM_CNT; i++) begin
         cnt_hit[i] = cnt_en[i] & cnt_ev[i] & (err_cnt_reg[i] == limit_of(i) - CNT_W'(1));
      end
   end

   // Event counters, cleared each interval and after a trigger
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < NUM_CNT; i++) begin
            err_cnt_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NUM_CNT; i++) begin
            if (win_end || !cnt_en[i] || cnt_hit[i]) begin
               err_cnt_reg[i] <= '0;
            end else if (cnt_ev[i]) begin
               err_cnt_reg[i] <= err_cnt_reg[i] + CNT_W'(1);
            end
         end
      end
   end

   // Edge detect of level causes
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         energy_d_reg <= 1'b0;
         descr_d_reg  <= 1'b0;
      end else begin
         energy_d_reg <= energy_lost_i;
         descr_d_reg  <= descr_loss_i;
      end
   end

   assign trig[CAUSE_RXERR]  = cnt_hit[0];
   assign trig[CAUSE_MLT3]   = cnt_hit[1];
   assign trig[CAUSE_SNR]    = cnt_hit[2];
   assign trig[CAUSE_ENERGY] = lct_reg[LCT_ENERGY] & energy_lost_i & ~energy_d_reg;
   assign trig[CAUSE_DESCR]  = lct_reg[LCT_DESCR] & descr_loss_i & ~descr_d_reg;

   // Drop pulse and cause latch; a new cause beats a read clear
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         link_drop_reg <= 1'b0;
         lds_reg       <= '0;
      end else begin
         link_drop_reg <= |trig;
         if (rd_ack && idx == IDX_LINK_DROP_CAUSE_STATUS) begin
            lds_reg <= (lds_reg & ~readdata_reg[LDS_LSB+CAUSE_W-1:LDS_LSB]) | trig;
         end else begin
            lds_reg <= lds_reg | trig;
         end
      end
   end

   // Interrupt status, write one to clear; a new cause beats the clear
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_stat_reg <= '0;
      end else if (wr_ack && idx == IDX_IRQ_STATUS && byteenable_i[0]) begin
         irq_stat_reg <= (irq_stat_reg & ~writedata_i[CAUSE_W-1:0]) | trig;
      end else begin
         irq_stat_reg <= irq_stat_reg | trig;
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_mask_reg <= '0;
      end else if (wr_ack && idx == IDX_IRQ_MASK && byteenable_i[0]) begin
         irq_mask_reg <= writedata_i[CAUSE_W-1:0];
      end
   end

   // Mirroring needs both swaps at once
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mirror_reg <= 1'b0;
      end else begin
         mirror_reg <= lct_reg[LCT_POL] & lct_reg[LCT_XOVER];
      end
   end

   // Level interrupt from unmasked status bits
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   assign readdata_o        = readdata_reg;
   assign waitrequest_o     = wait_reg;
   assign eq_coef0_bypass_o = lct_reg[LCT_COEF0];
   assign eq_err_bypass_o   = lct_reg[LCT_EQ_ERR];
   assign polarity_swap_o   = lct_reg[LCT_POL];
   assign crossover_swap_o  = lct_reg[LCT_XOVER];
   assign port_mirror_o     = mirror_reg;
   assign link_drop_o       = link_drop_reg;
   assign irq_o             = irq_reg;

endmodule : link_drop_regs

/* test/link_drop_regs_assertions.sv */
// Concurrent checks on the link drop register bank ports.
// Bound to every link_drop_regs instance; sees its ports only.
`timescale 1ns/1ps
module link_drop_regs_assertions
   import link_drop_regs_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   // Register bus
   input  wire logic [7:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   input  wire logic [3:0]  byteenable_i,
   input  wire logic [31:0] readdata_o,
   input  wire logic        waitrequest_o,
   // Datapath
   input  wire logic        rx_err_i,
   input  wire logic        mlt3_viol_i,
   input  wire logic        low_snr_i,
   input  wire logic        energy_lost_i,
   input  wire logic        descr_loss_i,
   input  wire logic        eq_coef0_bypass_o,
   input  wire logic        polarity_swap_o,
   input  wire logic        crossover_swap_o,
   input  wire logic        port_mirror_o,
   input  wire logic        link_drop_o
);
   logic [15:0] lct_reg;
   logic [1:0]  lvl_reg;
   logic        cause_reg;
   logic        wr_lct;
   assign wr_lct = write_i && !waitrequest_o && address_i[7:2] == IDX_LINK_CONTROL_THREE;

   // Shadow of control three, and any trigger source of the last cycle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lct_reg   <= LCT_RESET;
         lvl_reg   <= 2'h0;
         cause_reg <= 1'b0;
      end else begin
         if (wr_lct && byteenable_i[0]) lct_reg[7:0] <= writedata_i[7:0];
         if (wr_lct && byteenable_i[1]) lct_reg[15:8] <= writedata_i[15:8];
         lvl_reg   <= {descr_loss_i, energy_lost_i};
         cause_reg <= rx_err_i | mlt3_viol_i | low_snr_i
                      | |({descr_loss_i, energy_lost_i} & ~lvl_reg);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_rd_ack(idx);
      read_i && !waitrequest_o && address_i[7:2] == idx;
   endsequence
   sequence s_rise_en(lvl, en);
      $rose(lvl) && en;
   endsequence

   a_coef_bypass: assert property (eq_coef0_bypass_o == lct_reg[LCT_COEF0])
      else $error("coef bypass differs from control bit");
   a_pol_swap: assert property (polarity_swap_o == lct_reg[LCT_POL])
      else $error("polarity swap differs from control bit");
   a_xover_swap: assert property (crossover_swap_o == lct_reg[LCT_XOVER])
      else $error("crossover swap differs from control bit");
   a_port_mirror: assert property (
      port_mirror_o == $past(lct_reg[LCT_POL] && lct_reg[LCT_XOVER]))
      else $error("mirror not the and of both swaps");
   a_energy_drop: assert property (
      s_rise_en(energy_lost_i, lct_reg[LCT_ENERGY]) |=> link_drop_o)
      else $error("no drop after energy loss");
   a_descr_drop: assert property (
      s_rise_en(descr_loss_i, lct_reg[LCT_DESCR]) |=> link_drop_o)
      else $error("no drop after descrambler loss");
   a_drop_cause: assert property (link_drop_o |-> cause_reg)
      else $error("drop without any trigger source");
   a_status_rsvd: assert property (
      s_rd_ack(IDX_LINK_DROP_CAUSE_STATUS) |-> readdata_o[15:9] == 0 && readdata_o[3:0] == 0)
      else $error("cause status reserved bits set");
   a_cmd_rsvd: assert property (
      s_rd_ack(IDX_EXTENDED_ACCESS_CONTROL) |-> readdata_o[13:5] == 0)
      else $error("access control reserved bits set");
endmodule : link_drop_regs_assertions

bind link_drop_regs link_drop_regs_assertions chk_u (.*);

/* test/phy_event_model.sv */
// Far-side PHY datapath model: event pulses and level causes.
// Driven by the bench through its tasks; shares the bank clock.
`timescale 1ns/1ps
module phy_event_model (
   // Clock
   input  wire logic clk_i,
   // Event and level outputs
   output logic      rx_err_o,
   output logic      mlt3_viol_o,
   output logic      low_snr_o,
   output logic      energy_lost_o,
   output logic      descr_loss_o
);
   logic [4:0] ev_reg = 5'h00;
   assign {descr_loss_o, rx_err_o, mlt3_viol_o, low_snr_o, energy_lost_o} = ev_reg;

   // Hold one event line high for n back to back cycles
   task automatic burst(input int idx, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         ev_reg[idx] <= 1'b1;
      end
      @(posedge clk_i);
      ev_reg[idx] <= 1'b0;
   endtask : burst

   task automatic level(input int idx, input logic v);
      @(posedge clk_i);
      ev_reg[idx] <= v;
   endtask : level
endmodule : phy_event_model

/* test/tb.sv */
// Self-checking bench for the link drop register bank.
// Drives the Avalon-MM port and the PHY event model; one clock.
`timescale 1ns/1ps
module tb;
   import link_drop_regs_pkg::*;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [7:0]  address_i = 8'h00;
   logic        read_i = 1'b0;
   logic        write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0;
   logic [3:0]  byteenable_i = 4'h0;
   logic [31:0] readdata_o, rd;
   logic        waitrequest_o, rx_err_i, mlt3_viol_i, low_snr_i, energy_lost_i, descr_loss_i;
   logic        eq_coef0_bypass_o, eq_err_bypass_o, polarity_swap_o, crossover_swap_o;
   logic        port_mirror_o, link_drop_o, irq_o;
   logic [3:0]  swaps;
   int          fail_count = 0;
   int          compares = 0;
   int          drops = 0;
   int          cyc = 0;
   int          d0;
   int          lims [4] = '{0, SNR_LIMIT, MLT3_LIMIT, RXERR_LIMIT};

   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (link_drop_o === 1'b1) drops <= drops + 1;
   end

   link_drop_regs dut_u (.*);
   phy_event_model phy_u (.clk_i(clk_i), .rx_err_o(rx_err_i), .mlt3_viol_o(mlt3_viol_i),
      .low_snr_o(low_snr_i), .energy_lost_o(energy_lost_i), .descr_loss_o(descr_loss_i));
   assign swaps = {eq_coef0_bypass_o, polarity_swap_o, crossover_swap_o, port_mirror_o};

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out

   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      read_i <= !wr;
      write_i <= wr;
      address_i <= {idx, 2'h0};
      writedata_i <= {16'h0, d};
      byteenable_i <= 4'h3;
      do begin
         @(posedge clk_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 50);
      rd = readdata_o;
      read_i <= 1'b0;
      write_i <= 1'b0;
      if (n >= 50) begin
         fail_count++;
         close_out();
      end
   endtask : bus

   task automatic wr(input logic [5:0] idx, input logic [15:0] d);
      bus(1'b1, idx, d);
   endtask : wr

   task automatic rd_chk(input logic [5:0] idx, input logic [15:0] exp);
      bus(1'b0, idx, 16'h0);
      check(rd, {16'h0, exp});
   endtask : rd_chk

   // Start bursts well inside a fixed counting window
   task automatic align();
      for (int i = 0; i < 1100 && cyc % 1000 != 300; i++) @(posedge clk_i);
      d0 = drops;
   endtask : align

   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : settle

   initial begin
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      rd_chk(IDX_LINK_CONTROL_THREE, LCT_RESET);
      check(eq_err_bypass_o, 1);
      wr(IDX_LINK_CONTROL_THREE, 16'h0260);
      settle(2);
      check(swaps, 4'hf);
      wr(IDX_LINK_CONTROL_THREE, 16'h0040);
      settle(2);
      check(swaps, 4'h4);
      wr(IDX_LINK_CONTROL_THREE, 16'hffff);
      rd_chk(IDX_LINK_CONTROL_THREE, 16'hf7ff);
      wr(6'h00, 16'h1234);
      rd_chk(6'h00, 16'h0000);
      $display("test control done");
      for (int k = 1; k <= 3; k++) begin
         wr(IDX_LINK_CONTROL_THREE, 16'h0000);
         align();
         phy_u.burst(k, lims[k]);
         settle(3);
         check(drops, d0);
         wr(IDX_LINK_CONTROL_THREE, 16'h1 << k);
         align();
         phy_u.burst(k, lims[k] - 1);
         settle(3);
         check(drops, d0);
         phy_u.burst(k, 1);
         settle(3);
         check(drops, d0 + 1);
         rd_chk(IDX_LINK_DROP_CAUSE_STATUS, 16'h10 << k);
         rd_chk(IDX_LINK_DROP_CAUSE_STATUS, 16'h0000);
      end
      $display("test counted causes done");
      wr(IDX_IRQ_STATUS, 16'h001f);
      wr(IDX_LINK_CONTROL_THREE, 16'h0000);
      d0 = drops;
      phy_u.level(0, 1'b1);
      phy_u.level(0, 1'b0);
      settle(3);
      check(drops, d0);
      wr(IDX_LINK_CONTROL_THREE, 16'h0401);
      phy_u.level(0, 1'b1);
      phy_u.level(4, 1'b1);
      settle(3);
      check(drops, d0 + 2);
      rd_chk(IDX_LINK_DROP_CAUSE_STATUS, 16'h0110);
      rd_chk(IDX_IRQ_STATUS, 16'h0011);
      check(irq_o, 0);
      wr(IDX_IRQ_MASK, 16'h0010);
      settle(1);
      check(irq_o, 1);
      wr(IDX_IRQ_STATUS, 16'h0010);
      settle(1);
      check(irq_o, 0);
      rd_chk(IDX_IRQ_STATUS, 16'h0001);
      $display("test level causes done");
      wr(IDX_EXTENDED_ACCESS_CONTROL, 16'h001f);
      wr(IDX_EXTENDED_ADDRESS_DATA, 16'h0002);
      rd_chk(IDX_EXTENDED_ADDRESS_DATA, 16'h0002);
      wr(IDX_EXTENDED_ACCESS_CONTROL, 16'h401f);
      wr(IDX_EXTENDED_ADDRESS_DATA, 16'haaaa);
      for (int i = 0; i < 2; i++) rd_chk(IDX_EXTENDED_ADDRESS_DATA, 16'haaaa);
      wr(IDX_EXTENDED_ACCESS_CONTROL, 16'h801f);
      rd_chk(IDX_EXTENDED_ADDRESS_DATA, 16'haaaa);
      wr(IDX_EXTENDED_ADDRESS_DATA, 16'h3333);
      rd_chk(IDX_EXTENDED_ADDRESS_DATA, 16'h0000);
      wr(IDX_EXTENDED_ACCESS_CONTROL, 16'h001f);
      rd_chk(IDX_EXTENDED_ADDRESS_DATA, 16'h0005);
      wr(IDX_EXTENDED_ACCESS_CONTROL, 16'hc01f);
      for (int i = 0; i < 2; i++) rd_chk(IDX_EXTENDED_ADDRESS_DATA, 16'h0000);
      wr(IDX_EXTENDED_ADDRESS_DATA, 16'h4444);
      wr(IDX_EXTENDED_ACCESS_CONTROL, 16'h001f);
      rd_chk(IDX_EXTENDED_ADDRESS_DATA, 16'h0006);
      wr(IDX_EXTENDED_ADDRESS_DATA, 16'h0003);
      wr(IDX_EXTENDED_ACCESS_CONTROL, 16'h401f);
      rd_chk(IDX_EXTENDED_ADDRESS_DATA, 16'h3333);
      wr(IDX_EXTENDED_ACCESS_CONTROL, 16'h0003);
      rd_chk(IDX_EXTENDED_ADDRESS_DATA, 16'h0000);
      wr(IDX_EXTENDED_ACCESS_CONTROL, 16'h0005);
      wr(IDX_EXTENDED_ADDRESS_DATA, 16'h0009);
      rd_chk(IDX_EXTENDED_ADDRESS_DATA, 16'h0000);
      wr(IDX_EXTENDED_ACCESS_CONTROL, 16'hffff);
      rd_chk(IDX_EXTENDED_ACCESS_CONTROL, 16'hc01f);
      rd_chk(IDX_EXTENDED_ADDRESS_DATA, 16'h3333);
      $display("test extended access done");
      close_out();
   end
endmodule : tb
